// ===== shared/tdm_chain_map.svh
`ifndef TDM_CHAIN_MAP_SVH
`define TDM_CHAIN_MAP_SVH
`define SLOT_BITS 64
`define SAMPLE_BITS 32
`define CHAIN_MASTER_DEVICES 4
`define MCLK_PER_FRAME 256
`define BITS_PER_FRAME_MASTER 256
`define MCLK_PER_BIT 1
`define SERVO_RES_PS 5
`define RAM_PTR_BITS 6
`define ROM_PTR_BITS 20
`define SERVO_BITS 26
`define SYNC_PINS 4
`define PIN_BCLK 0
`define PIN_FCLK 1
`define PIN_MCLK 2
`define PIN_SDI 3
`endif

// ===== shared/tdm_chain_pkg.sv
`include "tdm_chain_map.svh"
package tdm_chain_pkg;
  typedef enum logic [1:0] {
    PORT_MASTER_NONE = 2'h0,
    PORT_MASTER_IN = 2'h1,
    PORT_MASTER_OUT = 2'h2
  } port_master_t;
  typedef logic [`SLOT_BITS-1:0] slot_t;
  typedef logic [`SAMPLE_BITS-1:0] sample_t;
  typedef logic [`SERVO_BITS-1:0] servo_t;
endpackage

// ===== rtl/pin_sync.sv
`timescale 1ns/1ps
module pin_sync
(
  input wire logic clk,
  input wire logic rst_n,
  input wire logic ce,
  input wire logic async_in,
  output logic sync_out
)
;
  typedef struct packed
  {
    logic stage1_reg;
    logic stage2_reg;
  } sync_state_t;
  sync_state_t st_reg;
  sync_state_t st_next;
  // first stage feeds only the second
  always_comb
  begin
    st_next = st_reg;
    if (ce)
    begin
      st_next.stage1_reg = async_in;
      st_next.stage2_reg = st_reg.stage1_reg;
    end
  end
  always_ff @(posedge clk or negedge rst_n)
  begin
    if (!rst_n)
      st_reg <= '0;
    else
      st_reg <= st_next;
  end
  assign sync_out = st_reg.stage2_reg;
endmodule

// ===== rtl/tdm_chain_out.sv
`timescale 1ns/1ps
// Operation
// [R1] 64-bit parallel-load output shift register
// [R2] frame pulse loads left and right together
// [R3] chain input in, serial data out
// [R4] advance on bit clock, devices cascade
// [R5] system limits chain to 25 MHz
// [R6] master mode fixes chain at four
// [R7] at most one port is master
// [R8] external master clock is 256 fs
// [R9] servo offset resolution 5 ps
// [R10] integer addresses RAM, fraction addresses ROM
// [R11] left first, msb first
`include "tdm_chain_map.svh"
module tdm_chain_out
  import tdm_chain_pkg::*;
(
  input wire logic clk,
  input wire logic rst_n,
  input wire logic ce,
  input wire tdm_chain_pkg::sample_t left_sample,
  input wire tdm_chain_pkg::sample_t right_sample,
  input wire tdm_chain_pkg::servo_t servo_ramp,
  input wire logic in_port_master,
  input wire logic out_port_master,
  input wire logic master_clock,
  input wire logic bit_clock_in,
  input wire logic frame_clock_in,
  input wire logic chain_serial_in,
  output logic output_serial_data,
  output logic bit_clock_out,
  output logic bit_clock_oe_n,
  output logic frame_clock_out,
  output logic frame_clock_oe_n,
  output tdm_chain_pkg::port_master_t master_sel,
  output logic config_error,
  output logic [`RAM_PTR_BITS-1:0] ram_pointer,
  output logic [`ROM_PTR_BITS-1:0] rom_pointer
)
;
  import tdm_chain_pkg::*;

  typedef struct packed
  {
    slot_t shift_reg;
    logic bclk_prev_reg;
    logic fclk_prev_reg;
    logic mclk_prev_reg;
    logic gen_bclk_reg;
    logic gen_fclk_reg;
    logic [7:0] bit_cnt_reg;
    logic load_pend_reg;
    logic sdo_reg;
    port_master_t master_reg;
    logic cfg_err_reg;
    logic [`RAM_PTR_BITS-1:0] ram_ptr_reg;
    logic [`ROM_PTR_BITS-1:0] rom_ptr_reg;
  } out_state_t;

  // all state but the pin synchronisers lives in one register pair
  out_state_t st_reg;
  out_state_t st_next;
  // last bit index of the fixed four-device master frame
  localparam logic [7:0] last_bit_idx = 8'(`BITS_PER_FRAME_MASTER - 1);

  logic [`SYNC_PINS-1:0] pin_raw;
  logic [`SYNC_PINS-1:0] pin_s;
  logic bclk_s;
  logic fclk_s;
  logic mclk_s;
  logic sdi_s;

  // gather the asynchronous pins, one synchroniser each
  assign pin_raw[`PIN_BCLK] = bit_clock_in;
  assign pin_raw[`PIN_FCLK] = frame_clock_in;
  assign pin_raw[`PIN_MCLK] = master_clock;
  assign pin_raw[`PIN_SDI] = chain_serial_in;

  // every pin crosses two flops before use; the first flop may
  // go metastable, so only the second one feeds the logic
  for (genvar i = 0; i < `SYNC_PINS; i++)
  begin : g_sync
    pin_sync u_sync
    (
      .clk(clk),
      .rst_n(rst_n),
      .ce(ce),
      .async_in(pin_raw[i]),
      .sync_out(pin_s[i])
    );
  end

  // synchronised pins back under their own names
  assign bclk_s = pin_s[`PIN_BCLK];
  assign fclk_s = pin_s[`PIN_FCLK];
  assign mclk_s = pin_s[`PIN_MCLK];
  assign sdi_s = pin_s[`PIN_SDI];

  logic bclk_eff;
  logic fclk_eff;
  logic bclk_fall;
  logic fclk_rise;
  logic mclk_fall;

  // edges against last cycle's level; history resets low like the
  // idle pins, so no false edge follows reset
  always_comb
  begin
    // master uses the generated clocks, slave the sampled pins
    bclk_eff = (st_reg.master_reg == PORT_MASTER_OUT) ? st_reg.gen_bclk_reg : bclk_s;
    fclk_eff = (st_reg.master_reg == PORT_MASTER_OUT) ? st_reg.gen_fclk_reg : fclk_s;
    bclk_fall = !bclk_eff && st_reg.bclk_prev_reg;
    fclk_rise = fclk_eff && !st_reg.fclk_prev_reg;
    mclk_fall = !mclk_s && st_reg.mclk_prev_reg;
  end

  always_comb
  begin
    st_next = st_reg;
    if (ce)
    begin
      // edge history, frozen with everything else while ce is low
      st_next.bclk_prev_reg = bclk_eff;
      st_next.fclk_prev_reg = fclk_eff;
      st_next.mclk_prev_reg = mclk_s;

      // one master at most; both asked means output stays slave
      if (in_port_master && out_port_master) // [R7]
      begin
        st_next.master_reg = PORT_MASTER_IN;
        st_next.cfg_err_reg = 1'b1;
      end
      else if (out_port_master)
      begin
        st_next.master_reg = PORT_MASTER_OUT;
        st_next.cfg_err_reg = 1'b0;
      end
      else if (in_port_master)
      begin
        st_next.master_reg = PORT_MASTER_IN;
        st_next.cfg_err_reg = 1'b0;
      end
      else
      begin
        st_next.master_reg = PORT_MASTER_NONE;
        st_next.cfg_err_reg = 1'b0;
      end

      // master: one bit per master clock, so a 256 fs master clock
      // gives exactly one four-device frame per output sample
      if (st_reg.master_reg == PORT_MASTER_OUT)
      begin
        st_next.gen_bclk_reg = mclk_s;
        if (mclk_fall)
        begin
          st_next.bit_cnt_reg = st_reg.bit_cnt_reg + 8'h01; // [R6] wraps at 256 bits
          st_next.gen_fclk_reg = (st_reg.bit_cnt_reg == last_bit_idx); // [R6]
        end
      end
      else
      begin
        // generator parked low so a later master entry starts a clean frame
        st_next.gen_bclk_reg = 1'b0;
        st_next.gen_fclk_reg = 1'b0;
        st_next.bit_cnt_reg = 8'h00;
      end

      // frame pulse arms a load at the next falling bit clock;
      // held so a pulse that ends before that fall still loads
      if (fclk_rise)
        st_next.load_pend_reg = 1'b1;

      if (bclk_fall)
      begin
        if (st_reg.load_pend_reg || fclk_rise)
        begin
          st_next.shift_reg = {left_sample, right_sample}; // [R1] [R2] [R11]
          st_next.sdo_reg = left_sample[`SAMPLE_BITS-1]; // [R11]
          st_next.load_pend_reg = 1'b0;
        end
        else
        begin
          // chain bit enters low end, msb leaves first
          st_next.shift_reg = {st_reg.shift_reg[`SLOT_BITS-2:0], sdi_s}; // [R3] [R4]
          st_next.sdo_reg = st_reg.shift_reg[`SLOT_BITS-2]; // [R3]
        end
      end

      // servo ramp split: integer high part, fraction low part;
      // pointers lag the ramp by one cycle, no filtering here
      st_next.ram_ptr_reg = servo_ramp[`SERVO_BITS-1:`ROM_PTR_BITS]; // [R10]
      st_next.rom_ptr_reg = servo_ramp[`ROM_PTR_BITS-1:0]; // [R9] [R10]
    end
  end

  // single state register, cleared to the idle slave state
  always_ff @(posedge clk or negedge rst_n)
  begin
    if (!rst_n)
      st_reg <= '0;
    else
      st_reg <= st_next;
  end

  // serial data and generated clocks straight from flops
  assign output_serial_data = st_reg.sdo_reg;
  assign bit_clock_out = st_reg.gen_bclk_reg;
  assign frame_clock_out = st_reg.gen_fclk_reg;
  // enables low while driving
  assign bit_clock_oe_n = (st_reg.master_reg != PORT_MASTER_OUT);
  assign frame_clock_oe_n = (st_reg.master_reg != PORT_MASTER_OUT);

  // status and servo pointers, all registered
  assign master_sel = st_reg.master_reg;
  assign config_error = st_reg.cfg_err_reg;
  assign ram_pointer = st_reg.ram_ptr_reg;
  assign rom_pointer = st_reg.rom_ptr_reg;
endmodule

// ===== bench/tdm_chain_out_checker.sv
`timescale 1ns/1ps
module tdm_chain_out_checker
  import tdm_chain_pkg::*;
(
  input wire logic clk,
  input wire logic rst_n,
  input wire logic ce,
  input wire logic in_port_master,
  input wire logic out_port_master,
  input wire logic bit_clock_in,
  input wire logic frame_clock_in,
  input wire logic output_serial_data,
  input wire logic bit_clock_out,
  input wire logic bit_clock_oe_n,
  input wire logic frame_clock_out,
  input wire logic frame_clock_oe_n,
  input wire logic config_error,
  input wire sample_t left_sample,
  input wire servo_t servo_ramp,
  input wire port_master_t master_sel,
  input wire logic [5:0] ram_pointer,
  input wire logic [19:0] rom_pointer
);
  default clocking @(posedge clk); endclocking
  default disable iff (!rst_n);
  logic [9:0] nbit_reg;
  logic armed_reg;
  // bit rises per frame; first frame is partial
  always_ff @(posedge clk or negedge rst_n)
    if (!rst_n)
    begin
      nbit_reg <= 10'h0;
      armed_reg <= 1'b0;
    end
    else if ($rose(frame_clock_out))
    begin
      nbit_reg <= {9'h0, $rose(bit_clock_out)};
      armed_reg <= 1'b1;
    end
    else if ($rose(bit_clock_out))
      nbit_reg <= nbit_reg + 10'h1;
  a_ram_int: assert property (ce |=> ram_pointer == $past(servo_ramp[25:20]))
    else $error("ram pointer");
  a_rom_frac: assert property (ce |=> rom_pointer == $past(servo_ramp[19:0]))
    else $error("rom pointer");
  a_both_refused: assert property ((in_port_master && out_port_master) [*2] |-> config_error)
    else $error("no config error");
  a_error_slave: assert property (config_error |-> master_sel == PORT_MASTER_IN)
    else $error("master on error");
  a_slave_quiet: assert property ((master_sel != PORT_MASTER_OUT) [*2] |-> bit_clock_oe_n && frame_clock_oe_n)
    else $error("slave drives");
  a_master_drives: assert property ((master_sel == PORT_MASTER_OUT) [*2] |-> !bit_clock_oe_n && !frame_clock_oe_n)
    else $error("master idle");
  a_frame_len: assert property ($rose(frame_clock_out) && armed_reg |-> nbit_reg == 10'h100)
    else $error("frame length");
  a_shift_fall: assert property ($changed(output_serial_data) |->
    (master_sel == PORT_MASTER_OUT ? !bit_clock_out : !bit_clock_in))
    else $error("shift on rise");
  a_load_left: assert property ($rose(frame_clock_in) && master_sel == PORT_MASTER_NONE |->
    ##17 output_serial_data == left_sample[31])
    else $error("load wrong");
  cover property ($rose(frame_clock_out));
  cover property (config_error);
  cover property ($rose(frame_clock_in));
endmodule
bind tdm_chain_out tdm_chain_out_checker chk (.*);

// ===== bench/dsp_port_model.sv
`timescale 1ns/1ps
module dsp_port_model
(
  input wire logic serial_data,
  output logic bit_clock,
  output logic frame_clock,
  output logic chain_bit
);
  // clocks stand still low between frames
  initial
  begin
    bit_clock = 1'b0;
    frame_clock = 1'b0;
    chain_bit = 1'b0;
  end
  // 48 ns bit, under the chain limit; released chain toggles
  task automatic frame(input logic [63:0] chain, output logic [127:0] got);
    frame_clock = 1'b1;
    #24 bit_clock = 1'b1;
    #24 bit_clock = 1'b0;
    frame_clock = 1'b0;
    for (int i = 0; i < 128; i++)
    begin
      #24 bit_clock = 1'b1;
      got = {got[126:0], serial_data};
      chain_bit = i < 64 ? chain[63 - i] : ~chain_bit;
      #24 bit_clock = 1'b0;
    end
  endtask
endmodule

// ===== bench/src_tdm_chain_output_port_bench.sv
`timescale 1ns/1ps
`include "tdm_chain_map.svh"
module src_tdm_chain_output_port_bench;
  import tdm_chain_pkg::*;
  logic clk = 1'b0, rst_n = 1'b0, ce = 1'b1, in_port_master = 1'b0, out_port_master = 1'b0;
  logic master_clock = 1'b0, bit_clock_in, frame_clock_in, chain_serial_in, output_serial_data;
  logic bit_clock_out, bit_clock_oe_n, frame_clock_out, frame_clock_oe_n, config_error;
  sample_t left_sample = '0, right_sample = '0;
  servo_t servo_ramp = '0, s;
  port_master_t master_sel;
  logic [5:0] ram_pointer;
  logic [19:0] rom_pointer;
  logic [127:0] got;
  logic [63:0] chain;
  int err_total = 0, tests_run = 0, cycles = 0, cycles_at = 0;
  localparam int clk_per_mclk = 8; // 40 ns master clock over 5 ns clk
  tdm_chain_out uut (.clk, .rst_n, .ce, .left_sample, .right_sample, .servo_ramp, .in_port_master,
    .out_port_master, .master_clock, .bit_clock_in, .frame_clock_in, .chain_serial_in, .output_serial_data,
    .bit_clock_out, .bit_clock_oe_n, .frame_clock_out, .frame_clock_oe_n, .master_sel, .config_error,
    .ram_pointer, .rom_pointer);
  dsp_port_model dsp (.serial_data(output_serial_data), .bit_clock(bit_clock_in), .frame_clock(frame_clock_in),
    .chain_bit(chain_serial_in));
  always #2.5 clk = ~clk;
  always #20 master_clock = ~master_clock;
  // servo ramp random every cycle
  always @(posedge clk)
    servo_ramp <= #1 servo_t'($urandom);
  // hang guard
  always @(posedge clk)
    if (++cycles > 30000)
    begin
      err_total++;
      give_verdict();
    end
  function automatic logic [127:0] exp_frame(sample_t l, sample_t r, logic [63:0] c);
    return {l, r, c};
  endfunction
  task automatic chk(input string what, input logic [127:0] exp, input logic [127:0] seen);
    tests_run++;
    if (seen !== exp)
    begin
      err_total++;
      $display("FAIL %s expected %h seen %h", what, exp, seen);
    end
  endtask
  task automatic give_verdict();
    if (err_total == 0 && tests_run > 0)
      $display("Finished cleanly");
    else
      $display("Finished with errors");
    $finish;
  endtask
  initial
  begin
    void'($urandom(46));
    repeat (4) @(posedge clk);
    #1 rst_n = 1'b1;
    repeat (4)
    begin
      @(posedge clk) s = servo_ramp;
      #2 chk("ptr", {s[25:20], s[19:0]}, {ram_pointer, rom_pointer});
    end
    // clock enable low must freeze the pointers while the ramp moves
    @(posedge clk);
    #1 ce = 1'b0;
    s = {ram_pointer, rom_pointer};
    repeat (3) @(posedge clk);
    #1 chk("freeze", s, {ram_pointer, rom_pointer});
    ce = 1'b1;
    for (int k = 0; k < 6; k++)
    begin
      @(posedge clk);
      #1 left_sample = k ? sample_t'($urandom) : 32'h80000001;
      right_sample = k ? sample_t'($urandom) : 32'h7FFFFFFE;
      chain = {$urandom, $urandom};
      dsp.frame(chain, got);
      chk("frame", exp_frame(left_sample, right_sample, chain), got);
    end
    @(posedge clk);
    #1 in_port_master = 1'b1;
    out_port_master = 1'b1;
    repeat (4) @(posedge clk);
    #1 chk("refuse", {config_error, bit_clock_oe_n, master_sel}, {2'h3, PORT_MASTER_IN});
    in_port_master = 1'b0;
    repeat (9000) @(posedge clk);
    #1 chk("master", {config_error, bit_clock_oe_n, frame_clock_oe_n, master_sel}, {3'h0, PORT_MASTER_OUT});
    // generated frame spans four 64-bit slots of master clock bits
    @(posedge frame_clock_out) cycles_at = cycles;
    @(posedge frame_clock_out);
    chk("frame period", `BITS_PER_FRAME_MASTER * clk_per_mclk, cycles - cycles_at);
    give_verdict();
  end
endmodule
